// ### rtl/acc_pkg.sv
// Constants for the analog comparator control block.
// Assumes a 32-bit AHB-Lite slave with word-aligned registers.
package acc_pkg;

    // ----------------------------------------------------------------
    // Register indices and byte addresses
    // ----------------------------------------------------------------
    localparam logic [7:0]  IDX_CMP_CONTROL = 8'hB7;
    localparam logic [7:0]  IDX_CMP_CONFIG  = 8'hB6;
    localparam logic [7:0]  IDX_IRQ_ENABLE  = 8'hA9;
    localparam logic [11:0] ADDR_CMP_CONTROL = {2'h0, IDX_CMP_CONTROL, 2'h0};
    localparam logic [11:0] ADDR_CMP_CONFIG  = {2'h0, IDX_CMP_CONFIG, 2'h0};
    localparam logic [11:0] ADDR_IRQ_ENABLE  = {2'h0, IDX_IRQ_ENABLE, 2'h0};

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int BIT_ENABLE   = 7;
    localparam int BIT_FLAG     = 6;
    localparam int BIT_LEVEL    = 5;
    localparam int BIT_IRQ_EN   = 5;
    localparam int BIT_POS_SRC  = 4;
    localparam int NREF_LSB     = 0;
    localparam int MODE_LSB     = 2;
    localparam int PSEL_LSB     = 0;

    // ----------------------------------------------------------------
    // Reset values and encodings
    // ----------------------------------------------------------------
    localparam logic [3:0] NREF_EXTERNAL = 4'h0;
    localparam logic [1:0] RST_2BIT      = 2'h0;
    localparam logic [3:0] RST_4BIT      = 4'h0;
    localparam logic [3:0] RST_PIN_ONEHOT = 4'h1; // Select 00 picks pin one

    typedef enum logic [1:0] {
        ACC_MODE_NONE,
        ACC_MODE_RISE,
        ACC_MODE_FALL,
        ACC_MODE_BOTH
    } acc_mode_e;

    // HTRANS encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ    = 2'h3;

endpackage

// ### rtl/acc_sync.sv
// Two-stage synchroniser for a single level.
// Assumes the input may change at any time relative to hclk.
`timescale 1ns/1ns
module acc_sync
(
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic async_in,
    output logic      sync_out
);
    logic meta_ff;

    // ----------------------------------------------------------------
    // Synchroniser chain
    // ----------------------------------------------------------------
    // First stage is read only by the second stage
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            meta_ff  <= 1'b0;
            sync_out <= 1'b0;
        end
        else
        begin
            meta_ff  <= async_in;
            sync_out <= meta_ff;
        end
    end
endmodule // acc_sync

// ### rtl/acc_edge.sv
// Edge classifier for the synchronised comparator output.
// Assumes the input is already synchronous to hclk.
`timescale 1ns/1ns
module acc_edge
    import acc_pkg::*;
(
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       level_in,
    input  wire logic       active,
    input  wire logic [1:0] mode,
    output logic            level_prev,
    output logic            event_hit
);
    logic rise;
    logic fall;

    // ----------------------------------------------------------------
    // Previous sample
    // ----------------------------------------------------------------
    // Tracks while disabled too, so enabling never fakes an edge
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            level_prev <= 1'b0;
        else
            level_prev <= level_in;
    end

    // Edge terms
    assign rise = level_in & ~level_prev;
    assign fall = ~level_in & level_prev;

    // Mode decode
    always_comb
    begin
        case (acc_mode_e'(mode))
            ACC_MODE_NONE: event_hit = 1'b0;
            ACC_MODE_RISE: event_hit = active & rise;
            ACC_MODE_FALL: event_hit = active & fall;
            ACC_MODE_BOTH: event_hit = active & (rise | fall);
            default:       event_hit = 1'b0;
        endcase
    end
endmodule // acc_edge

// ### rtl/acc_top.sv
// Analog comparator control: registers, event flag, interrupt and wake.
// Assumes an AHB-Lite master on hclk and an analog comparator outside.
//
// Our own choice: the AHB-Lite register port.
`timescale 1ns/1ns
// What this block does
// - Comparator powered and active only while enable bit 7 is set.
// - Configured trigger condition sets event flag bit 6 in hardware.
// - Interrupt request only while flag and irq enable bit 5 are both set.
// - Hardware never clears the flag; software writes 0 to clear it.
// - Status bit 5 reads the comparator output level.
// - Negative select 0000 picks external pin, else n/16 of supply.
// - Exactly one of four positive input pins drives the comparator, none while the internal reference is selected.
// - Pending interrupt wakes from stop; detection needs hclk kept running.
// - Mode 00 none, 01 rising, 10 falling, 11 both edges.
// - Select 00..11 map to pins one to four; ignored for internal reference.
// - Positive-source bit 4 set applies the internal 1.5 V reference.
module acc_top
    import acc_pkg::*;
#(
    parameter int ADDR_W = 12
)
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        cmp_out,
    output logic             cmp_power_en,
    output logic [3:0]       nref_level_sel,
    output logic             nref_use_pin,
    output logic [3:0]       pos_pin_onehot,
    output logic             pos_use_internal,
    output logic             cmp_irq,
    output logic             wake_req
);
    // Decoder compares haddr[11:0]; a narrower bus cannot reach the map
    if (ADDR_W < 12)
    begin : g_addr_w_check
        $error("ADDR_W too small for the register map");
    end

    // Register state
    logic       enable_ff;
    logic       flag_ff;
    logic [3:0] nref_ff;
    logic       pos_src_ff;
    logic [1:0] mode_ff;
    logic [1:0] psel_ff;
    logic       irq_en_ff;
    logic       wr_pend_ff;
    logic [11:0] wr_addr_ff;
    logic       level_sync;
    logic       level_prev;
    logic       event_hit;
    logic       acc_valid;
    logic       clr_flag;
    logic [7:0] wbyte;
    logic [7:0] nxt_rbyte;
    logic [3:0] pin_pick;

    // ----------------------------------------------------------------
    // Event capture
    // ----------------------------------------------------------------
    // Raw level is asynchronous; it crosses two flops before any use
    acc_sync u_sync
    (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .async_in (cmp_out),
        .sync_out (level_sync)
    );

    // Edge classifier, gated by the enable bit
    acc_edge u_edge
    (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .level_in   (level_sync),
        .active     (enable_ff),
        .mode       (mode_ff),
        .level_prev (level_prev),
        .event_hit  (event_hit)
    );

    // ----------------------------------------------------------------
    // AHB-Lite slave
    // ----------------------------------------------------------------
    // Zero wait states, so the slave never stretches a transfer
    assign acc_valid = hsel & hready & htrans[1];
    assign wbyte     = hwdata[7:0];

    // Write strobe of one register word during its data phase
    function automatic logic wr_hit
    (
        input logic        pend,
        input logic [11:0] held,
        input logic [11:0] addr
    );
        return pend && (held == addr);
    endfunction

    // Address phase of a write is held for its data phase
    // so hwdata, which comes a cycle later, meets its address
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 12'h000;
        end
        else if (hready)
        begin
            wr_pend_ff <= acc_valid & hwrite;
            wr_addr_ff <= haddr[11:0];
        end
    end

    // Software clear of the event flag
    assign clr_flag = wr_hit(wr_pend_ff, wr_addr_ff, ADDR_CMP_CONTROL) && !wbyte[BIT_FLAG];

    // Control register writes
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            enable_ff <= 1'b0;
            nref_ff   <= RST_4BIT;
        end
        else if (wr_hit(wr_pend_ff, wr_addr_ff, ADDR_CMP_CONTROL))
        begin
            enable_ff <= wbyte[BIT_ENABLE];
            nref_ff   <= wbyte[NREF_LSB +: 4];
        end
    end

    // Configuration register writes
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pos_src_ff <= 1'b0;
            mode_ff    <= RST_2BIT;
            psel_ff    <= RST_2BIT;
        end
        else if (wr_hit(wr_pend_ff, wr_addr_ff, ADDR_CMP_CONFIG))
        begin
            pos_src_ff <= wbyte[BIT_POS_SRC];
            mode_ff    <= wbyte[MODE_LSB +: 2];
            psel_ff    <= wbyte[PSEL_LSB +: 2];
        end
    end

    // Interrupt enable register writes
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            irq_en_ff <= 1'b0;
        else if (wr_hit(wr_pend_ff, wr_addr_ff, ADDR_IRQ_ENABLE))
            irq_en_ff <= wbyte[BIT_IRQ_EN];
    end

    // Sticky flag: a new event outweighs a clear in the same cycle
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            flag_ff <= 1'b0;
        else if (event_hit)
            flag_ff <= 1'b1;
        else if (clr_flag)
            flag_ff <= 1'b0;
    end

    // Read mux; unmapped words read zero
    // Bit 4 is reserved; the status bit shows the synchronised level
    always_comb
    begin
        case (haddr[11:0])
            ADDR_CMP_CONTROL: nxt_rbyte = {enable_ff, flag_ff, level_sync, 1'b0, nref_ff};
            ADDR_CMP_CONFIG:  nxt_rbyte = {3'h0, pos_src_ff, mode_ff, psel_ff};
            ADDR_IRQ_ENABLE:  nxt_rbyte = {2'h0, irq_en_ff, 5'h00};
            default:          nxt_rbyte = 8'h00;
        endcase
    end

    // Read data registered at the address phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= 32'h0000_0000;
        else if (acc_valid && !hwrite)
            hrdata <= {24'h00_0000, nxt_rbyte};
    end

    // Always ready, always OKAY
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Analog steering and interrupt outputs
    // ----------------------------------------------------------------
    // One select line per positive pin; all low on the internal reference
    for (genvar g = 0; g < 4; g++)
    begin : g_pin
        assign pin_pick[g] = !pos_src_ff && (psel_ff == 2'(g));
    end

    // Wake is a plain level from flag and irq enable; the stop-mode clock domain
    // must keep hclk or a keep-alive running for detection to continue
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cmp_power_en     <= 1'b0;
            nref_level_sel   <= RST_4BIT;
            nref_use_pin     <= 1'b1;
            pos_pin_onehot   <= RST_PIN_ONEHOT;
            pos_use_internal <= 1'b0;
            cmp_irq          <= 1'b0;
            wake_req         <= 1'b0;
        end
        else
        begin
            cmp_power_en     <= enable_ff;
            nref_level_sel   <= nref_ff;
            nref_use_pin     <= (nref_ff == NREF_EXTERNAL);
            pos_use_internal <= pos_src_ff;
            pos_pin_onehot   <= pin_pick;
            cmp_irq          <= flag_ff & irq_en_ff;
            wake_req         <= flag_ff & irq_en_ff;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    // Interrupt, flag, power, event path and steering
    a_irq_gating: assert property (@(posedge hclk) disable iff (!hresetn)
        cmp_irq == $past(flag_ff & irq_en_ff)) else $error("irq not flag and enable");
    a_flag_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
        $fell(flag_ff) |-> $past(clr_flag)) else $error("flag cleared without write");
    a_event_sets: assert property (@(posedge hclk) disable iff (!hresetn)
        event_hit |=> flag_ff) else $error("event did not set flag");
    a_set_wins: assert property (@(posedge hclk) disable iff (!hresetn)
        (event_hit && clr_flag) |=> flag_ff) else $error("clear beat event");
    a_power_follow: assert property (@(posedge hclk) disable iff (!hresetn)
        !enable_ff |=> !cmp_power_en) else $error("powered while disabled");
    a_no_event_off: assert property (@(posedge hclk) disable iff (!hresetn)
        !enable_ff |-> !event_hit) else $error("event while disabled");
    a_sync_delay: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(cmp_out) ##1 cmp_out ##1 cmp_out |-> level_sync) else $error("sync latency");
    a_mode_none: assert property (@(posedge hclk) disable iff (!hresetn)
        (mode_ff == 2'h0) |-> !event_hit) else $error("event in mode none");
    a_pin_onehot: assert property (@(posedge hclk) disable iff (!hresetn)
        !$past(pos_src_ff) |-> $onehot(pos_pin_onehot)) else $error("pins not one-hot");
    a_nref_pin: assert property (@(posedge hclk) disable iff (!hresetn)
        nref_use_pin == ($past(nref_ff) == NREF_EXTERNAL)) else $error("nref pin select");
    a_wake_irq: assert property (@(posedge hclk) disable iff (!hresetn)
        wake_req == cmp_irq) else $error("wake differs from irq");

    // Bus read-back and event path
    a_read_level: assert property (@(posedge hclk) disable iff (!hresetn)
        (acc_valid && !hwrite && haddr[11:0] == ADDR_CMP_CONTROL)
        |=> hrdata[BIT_LEVEL] == $past(level_sync)) else $error("status bit stale");
    a_prev_track: assert property (@(posedge hclk) disable iff (!hresetn)
        level_prev == $past(level_sync)) else $error("previous sample lost");

    // Flag and steering outputs
    a_flag_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        (flag_ff && !clr_flag) |=> flag_ff) else $error("flag dropped by hardware");
    a_power_on: assert property (@(posedge hclk) disable iff (!hresetn)
        enable_ff |=> cmp_power_en) else $error("enabled but not powered");
    a_nref_level: assert property (@(posedge hclk) disable iff (!hresetn)
        nref_level_sel == $past(nref_ff)) else $error("nref level select");
    a_steer_internal: assert property (@(posedge hclk) disable iff (!hresetn)
        pos_use_internal == $past(pos_src_ff)) else $error("internal source select");

    // Main scenarios worth seeing at least once
    c_rise: cover property (@(posedge hclk) disable iff (!hresetn)
        mode_ff == 2'h1 && event_hit);
    c_fall: cover property (@(posedge hclk) disable iff (!hresetn)
        mode_ff == 2'h2 && event_hit);
    c_clear: cover property (@(posedge hclk) disable iff (!hresetn)
        $fell(flag_ff));
    c_irq: cover property (@(posedge hclk) disable iff (!hresetn) $rose(cmp_irq));
    c_set_wins: cover property (@(posedge hclk) disable iff (!hresetn)
        event_hit && clr_flag);
endmodule // acc_top

// ### bench/tb_analog_comparator_control.sv
// Self-checking bench for the comparator control block: register access,
// selector outputs, edge events, sticky flag and interrupt request.
// Assumes the acc_pkg constants and a zero-wait AHB-Lite slave in acc_top.
`timescale 1ns/1ns
module tb_analog_comparator_control
    import acc_pkg::*;
;
    logic        hclk, hresetn, hsel, hwrite, cmp_out;
    logic [31:0] haddr, hwdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    wire  [31:0] hrdata;
    wire         hreadyout, hresp, cmp_power_en, nref_use_pin, pos_use_internal;
    wire  [3:0]  nref_level_sel, pos_pin_onehot;
    wire         cmp_irq, wake_req;
    int          err_count, num_checks, cycles;
    int          m_en, m_flag, m_nref, m_lvl, m_prev, m_mode;
    logic [31:0] r;

    acc_top dut
    (
        .hclk             (hclk),
        .hresetn          (hresetn),
        .hsel             (hsel),
        .haddr            (haddr),
        .htrans           (htrans),
        .hwrite           (hwrite),
        .hsize            (hsize),
        .hwdata           (hwdata),
        .hready           (hreadyout),
        .hrdata           (hrdata),
        .hreadyout        (hreadyout),
        .hresp            (hresp),
        .cmp_out          (cmp_out),
        .cmp_power_en     (cmp_power_en),
        .nref_level_sel   (nref_level_sel),
        .nref_use_pin     (nref_use_pin),
        .pos_pin_onehot   (pos_pin_onehot),
        .pos_use_internal (pos_use_internal),
        .cmp_irq          (cmp_irq),
        .wake_req         (wake_req)
    );

    // ----------------------------------------------------------------
    // Clock, reset and hang guard
    // ----------------------------------------------------------------
    initial
    begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end

    // Whole run is under three hundred cycles; about seventeen times that means a hang
    always @(posedge hclk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            err_count++;
            tally_and_finish();
        end
    end

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic tally_and_finish();
        if (err_count == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask

    // One single transfer; address held until hready, data until hready
    task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= {20'h0, a};
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask

    function automatic logic [31:0] ctl_exp();
        return 32'((m_en << 7) | (m_flag << 6) | (m_lvl << 5) | m_nref);
    endfunction

    // Bit 6 written as 1 so the sticky flag is left alone
    task automatic set_ctl(input int en, input int nref);
        m_en   = en;
        m_nref = nref;
        ahb(1'b1, ADDR_CMP_CONTROL, 32'((en << 7) | 64 | nref));
    endtask

    task automatic clr_flag();
        m_flag = 0;
        ahb(1'b1, ADDR_CMP_CONTROL, 32'((m_en << 7) | m_nref));
    endtask

    // Model: edge against the previous level, events only while enabled
    task automatic drive(input int v);
        cmp_out <= v[0];
        if (m_en == 1 && v == 1 && m_prev == 0 && m_mode[0])
            m_flag = 1;
        if (m_en == 1 && v == 0 && m_prev == 1 && m_mode[1])
            m_flag = 1;
        m_prev = v;
        m_lvl  = v;
        cyc(5);
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        {hsel, hwrite, cmp_out, hresetn} = 4'h0;
        {haddr, hwdata, htrans} = '0;
        hsize = 3'h2;
        void'($urandom(32'hABB6));
        cyc(2);
        hresetn <= 1'b1;
        chk(32'({hreadyout, nref_use_pin, cmp_power_en, cmp_irq, hresp, pos_pin_onehot}),
            32'h181);
        ahb(1'b0, ADDR_CMP_CONTROL, 32'h0);
        chk(r, 32'h0);
        ahb(1'b0, ADDR_CMP_CONFIG, 32'h0);
        chk(r, 32'h0);
        ahb(1'b0, 12'h100, 32'h0);
        chk(r, 32'h0);
        ahb(1'b1, 12'h100, 32'hFF);
        ahb(1'b0, ADDR_CMP_CONTROL, 32'h0);
        chk(r, ctl_exp());
        // Every reference code, enable bit picked at random
        for (int i = 0; i < 16; i++)
        begin
            set_ctl(int'($urandom() & 1), i);
            cyc(2);
            chk(32'({cmp_power_en, nref_use_pin, nref_level_sel}),
                32'((m_en << 5) | ((i == 0) << 4) | i));
            ahb(1'b0, ADDR_CMP_CONTROL, 32'h0);
            chk(r, ctl_exp());
        end
        // Four pins one-hot, then the internal reference overrides
        for (int p = 0; p < 5; p++)
        begin
            ahb(1'b1, ADDR_CMP_CONFIG, 32'((p < 4) ? p : 19));
            cyc(2);
            chk(32'({pos_use_internal, pos_pin_onehot}), 32'((p < 4) ? (1 << p) : 16));
            ahb(1'b0, ADDR_CMP_CONFIG, 32'h0);
            chk(r, 32'((p < 4) ? p : 19));
        end
        // Each edge mode against a rise then a fall
        set_ctl(1, 5);
        for (int m = 0; m < 4; m++)
        begin
            m_mode = m;
            ahb(1'b1, ADDR_CMP_CONFIG, 32'(m << 2));
            clr_flag();
            drive(1);
            ahb(1'b0, ADDR_CMP_CONTROL, 32'h0);
            chk(r, ctl_exp());
            clr_flag();
            drive(0);
            ahb(1'b0, ADDR_CMP_CONTROL, 32'h0);
            chk(r, ctl_exp());
            clr_flag();
        end
        // Disabled comparator raises nothing; enabling adds no false edge
        set_ctl(0, 5);
        drive(1);
        drive(0);
        set_ctl(1, 5);
        cyc(4);
        ahb(1'b0, ADDR_CMP_CONTROL, 32'h0);
        chk(r, ctl_exp());
        // Request gated by enable, flag stays until software clears it
        drive(1);
        chk(32'({cmp_irq, wake_req}), 32'h0);
        ahb(1'b1, ADDR_IRQ_ENABLE, 32'h20);
        cyc(2);
        chk(32'({cmp_irq, wake_req}), 32'h3);
        cyc(20);
        ahb(1'b0, ADDR_CMP_CONTROL, 32'h0);
        chk(r, ctl_exp());
        ahb(1'b0, ADDR_IRQ_ENABLE, 32'h0);
        chk(r & 32'h20, 32'h20);
        clr_flag();
        cyc(2);
        chk(32'({cmp_irq, wake_req}), 32'h0);
        // Fall lands on the clearing write's data edge, so the set must win
        cmp_out <= 1'b0;
        if (m_en == 1 && m_prev == 1 && m_mode[1])
            m_flag = 1;
        m_prev = 0;
        m_lvl  = 0;
        cyc(1);
        ahb(1'b1, ADDR_CMP_CONTROL, 32'((m_en << 7) | m_nref));
        cyc(4);
        ahb(1'b0, ADDR_CMP_CONTROL, 32'h0);
        chk(r, ctl_exp());
        chk(32'({cmp_irq, wake_req}), 32'h3);
        tally_and_finish();
    end
endmodule // tb_analog_comparator_control
